/* logic/spllc_pkg.sv */
//
// Contract
// - Every frequency value in the registers is a 48-bit numerator over a 16-bit denominator.
// - A control bit selects whether the crystal feeds the PLL directly or through the doubler.
// - The feedback divider accepts any integer from 108 through 556.
// - At reset the control fields load from OTP or EEPROM, whichever is enabled and valid.
// - After the reset sequence the host may rewrite the control fields at any time.
// - Lock limits are derived automatically from the active configuration.
// - A loss-of-lock alarm is readable in status and routable to a GPIO output.
// - The PLL output is flagged as the source of all internal clocks once the reset load completes.
//
// ----------------------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------------------
package spllc_pkg;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_FREQ_M_LO = 12'h008;
  localparam logic [11:0] ADDR_FREQ_M_HI = 12'h00c;
  localparam logic [11:0] ADDR_FREQ_N = 12'h010;
  localparam logic [11:0] ADDR_LOCK_LIM = 12'h014;
  localparam logic [11:0] ADDR_GPIO_CFG = 12'h018;

  // Control word: bit 0 doubler, bits 25:16 feedback divider.
  localparam int CTRL_DBL_BIT = 0;
  localparam int CTRL_FB_LSB = 16;
  localparam int FB_W = 10;
  localparam logic [FB_W-1:0] FB_MIN = 10'h06c;
  localparam logic [FB_W-1:0] FB_MAX = 10'h22c;
  localparam logic [FB_W-1:0] FB_RESET = 10'h10e;
  localparam logic CTRL_DBL_RESET = 1'b0;

  // Status word: bit 0 lock-loss sticky, bit 1 locked now, bit 2 load done, bits 5:4 source.
  localparam int ST_LOL_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_SRC_LSB = 4;

  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_OTP = 2'h1;
  localparam logic [1:0] SRC_EEPROM = 2'h2;

  localparam int M_W = 48;
  localparam int N_W = 16;
  localparam int VCTL_W = 12;
  // Lock window half-width in control-voltage codes around the expected point.
  localparam logic [VCTL_W-1:0] LOCK_MARGIN = 12'h040;

  typedef struct packed {
    logic [M_W-1:0] num;
    logic [N_W-1:0] den;
  } spllc_freq_s;

  typedef struct packed {
    logic dbl_en;
    logic [FB_W-1:0] fb_div;
  } spllc_ctrl_s;

  typedef struct packed {
    logic en;
    logic valid;
    spllc_ctrl_s ctrl;
  } spllc_nvm_s;

  typedef struct packed {
    logic [VCTL_W-1:0] lo;
    logic [VCTL_W-1:0] hi;
  } spllc_lim_s;

endpackage : spllc_pkg

/* logic/spllc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module spllc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Nonvolatile sources presented at reset
  input wire spllc_pkg::spllc_nvm_s otp_img,
  input wire spllc_pkg::spllc_nvm_s eeprom_img,
  // Analog loop observation, asynchronous
  input wire logic [spllc_pkg::VCTL_W-1:0] loop_vctl,
  // Controls to the analog PLL
  output spllc_pkg::spllc_ctrl_s pll_ctrl,
  output logic pll_feeds_all_clocks,
  // Status pin
  output logic gpio_lol
);
  import spllc_pkg::*;

  typedef enum {ST_LOAD, ST_RUN} spllc_phase_e;

  typedef struct packed {
    spllc_phase_e phase;
    spllc_ctrl_s ctrl;
    spllc_freq_s freq;
    logic [1:0] src;
    logic gpio_route;
    logic lol_sticky;
    logic locked;
    spllc_lim_s lim;
    logic [VCTL_W-1:0] v1;
    logic [VCTL_W-1:0] v2;
    logic [VCTL_W-1:0] v3;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic gpio;
    logic feeds;
  } spllc_state_s;

  spllc_state_s st_q;
  spllc_state_s st_d;

  logic acc;
  logic in_win;
  logic [VCTL_W-1:0] centre;
  logic [FB_W-1:0] fb_in;

  // ----------------------------------------------------------------------------
  // Lock window derivation
  // ----------------------------------------------------------------------------
  // The expected control voltage scales with the divider position in its range;
  // the doubler shifts it by 0x200 codes. Coarse, but it tracks the configuration.
  always_comb begin
    centre = 12'(({2'h0, st_q.ctrl.fb_div} - {2'h0, FB_MIN}) << 2) + (st_q.ctrl.dbl_en ? 12'h200 : 12'h000);
  end

  always_comb begin
    acc = psel && penable && !st_q.pready;
    fb_in = pwdata[CTRL_FB_LSB +: FB_W];
    in_win = (st_q.v3 >= st_q.lim.lo) && (st_q.v3 <= st_q.lim.hi);
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    // Three stages; a level change counts only once the last two agree.
    st_d.v1 = loop_vctl;
    st_d.v2 = st_q.v1;
    st_d.v3 = st_q.v2;
    st_d.lim.lo = (centre > LOCK_MARGIN) ? 12'(centre - LOCK_MARGIN) : 12'h000;
    st_d.lim.hi = (centre < (12'hfff - LOCK_MARGIN)) ? 12'(centre + LOCK_MARGIN) : 12'hfff;
    case (st_q.phase)
      ST_LOAD: begin
        if (otp_img.en && otp_img.valid) begin
          st_d.ctrl = otp_img.ctrl;
          st_d.src = SRC_OTP;
        end else if (eeprom_img.en && eeprom_img.valid) begin
          st_d.ctrl = eeprom_img.ctrl;
          st_d.src = SRC_EEPROM;
        end else begin
          st_d.src = SRC_DEFAULT;
        end
        st_d.phase = ST_RUN;
      end
      ST_RUN: begin
        if (st_q.v2 == st_q.v3) begin
          st_d.locked = in_win;
        end
        // Set wins over a clear written in the same cycle.
        if (acc && pwrite && paddr == ADDR_STATUS && pwdata[ST_LOL_BIT]) begin
          st_d.lol_sticky = 1'b0;
        end
        if (st_q.locked && !st_d.locked) begin
          st_d.lol_sticky = 1'b1;
        end
      end
      default: begin
        st_d.phase = ST_LOAD;
      end
    endcase
    st_d.gpio = st_q.gpio_route && !st_q.locked;
    // Registered beside the phase so the output comes straight from a flip-flop.
    st_d.feeds = (st_d.phase == ST_RUN);
    if (acc) begin
      st_d.pready = 1'b1;
      st_d.prdata = 32'h0000_0000;
      if (pwrite) begin
        case (paddr)
          ADDR_CTRL: begin
            // Writes before the load completes are refused so the load is not corrupted.
            if (st_q.phase != ST_RUN || fb_in < FB_MIN || fb_in > FB_MAX) begin
              st_d.pslverr = 1'b1;
            end else begin
              st_d.ctrl.dbl_en = pwdata[CTRL_DBL_BIT];
              st_d.ctrl.fb_div = fb_in;
            end
          end
          ADDR_STATUS: begin
          end
          ADDR_FREQ_M_LO: begin
            st_d.freq.num[31:0] = pwdata;
          end
          ADDR_FREQ_M_HI: begin
            st_d.freq.num[47:32] = pwdata[15:0];
          end
          ADDR_FREQ_N: begin
            st_d.freq.den = pwdata[15:0];
          end
          ADDR_GPIO_CFG: begin
            st_d.gpio_route = pwdata[0];
          end
          default: begin
            st_d.pslverr = 1'b1;
          end
        endcase
      end else begin
        case (paddr)
          ADDR_CTRL: begin
            st_d.prdata[CTRL_DBL_BIT] = st_q.ctrl.dbl_en;
            st_d.prdata[CTRL_FB_LSB +: FB_W] = st_q.ctrl.fb_div;
          end
          ADDR_STATUS: begin
            st_d.prdata[ST_LOL_BIT] = st_q.lol_sticky;
            st_d.prdata[ST_LOCK_BIT] = st_q.locked;
            st_d.prdata[ST_DONE_BIT] = (st_q.phase == ST_RUN);
            st_d.prdata[ST_SRC_LSB +: 2] = st_q.src;
          end
          ADDR_FREQ_M_LO: begin
            st_d.prdata = st_q.freq.num[31:0];
          end
          ADDR_FREQ_M_HI: begin
            st_d.prdata[15:0] = st_q.freq.num[47:32];
          end
          ADDR_FREQ_N: begin
            st_d.prdata[15:0] = st_q.freq.den;
          end
          ADDR_LOCK_LIM: begin
            st_d.prdata[11:0] = st_q.lim.lo;
            st_d.prdata[27:16] = st_q.lim.hi;
          end
          ADDR_GPIO_CFG: begin
            st_d.prdata[0] = st_q.gpio_route;
          end
          default: begin
            st_d.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.phase <= ST_LOAD;
      st_q.ctrl.dbl_en <= CTRL_DBL_RESET;
      st_q.ctrl.fb_div <= FB_RESET;
      st_q.freq.den <= 16'h0001;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pll_ctrl = st_q.ctrl;
  assign gpio_lol = st_q.gpio;
  // The flag that the synthesizer output clocks every internal domain is low in reset and ST_LOAD, high from ST_RUN.
  assign pll_feeds_all_clocks = st_q.feeds;

endmodule : spllc_top
`default_nettype wire

/* test/spllc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module spllc_checker (
  // Watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire spllc_pkg::spllc_ctrl_s pll_ctrl,
  input wire logic pll_feeds_all_clocks
);
  import spllc_pkg::*;
  logic [31:0] wd_q;
  logic ctl_ok;
  logic done;
  // Write data is kept one cycle so the update can be compared after the edge.
  always_ff @(posedge pclk) wd_q <= pwdata;
  assign done = psel && penable && pready;
  assign ctl_ok = done && pwrite && paddr == ADDR_CTRL && !pslverr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  chk_ready_next: assert property (s_wait |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_fb_range: assert property (pll_ctrl.fb_div >= FB_MIN && pll_ctrl.fb_div <= FB_MAX)
    else $error("divider out of range");
  chk_fb_refuse: assert property (done && pwrite && paddr == ADDR_CTRL &&
    (pwdata[25:16] < FB_MIN || pwdata[25:16] > FB_MAX) |-> pslverr) else $error("bad divider taken");
  chk_ctrl_take: assert property (ctl_ok |=> pll_ctrl == {wd_q[0], wd_q[25:16]})
    else $error("control not taken");
  chk_ctrl_hold: assert property (pll_feeds_all_clocks && !(psel && penable && pwrite && paddr == ADDR_CTRL)
    |=> $stable(pll_ctrl))
    else $error("control changed");
  chk_bad_addr: assert property (done && paddr > ADDR_GPIO_CFG |-> pslverr) else $error("unmapped taken");
  chk_load_done: assert property ($rose(presetn) |-> ##[0:2] pll_feeds_all_clocks)
    else $error("load late");
  chk_feed_stay: assert property (pll_feeds_all_clocks |=> pll_feeds_all_clocks)
    else $error("clock source dropped");
endmodule : spllc_checker
bind spllc_top spllc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .pll_ctrl, .pll_feeds_all_clocks);
`default_nettype wire

/* test/spllc_loop_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spllc_loop_model (
  // Controls from the block
  input wire spllc_pkg::spllc_ctrl_s pll_ctrl,
  // Pulls the loop off its lock point
  input wire logic knock,
  // Loop filter voltage code
  output logic [spllc_pkg::VCTL_W-1:0] loop_vctl
);
  import spllc_pkg::*;
  logic [VCTL_W-1:0] centre;
  // The loop settles at once; real settling is slower, so only steady states are judged.
  assign centre = ({2'h0, pll_ctrl.fb_div - FB_MIN} << 2) + (pll_ctrl.dbl_en ? 12'h200 : 12'h000);
  assign loop_vctl = knock ? centre + 12'h400 : centre;
endmodule : spllc_loop_model
`default_nettype wire

/* test/spllc_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module spllc_tb_top;
  import spllc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, knock, gpio_lol, feeds, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  spllc_nvm_s otp_img, eeprom_img;
  spllc_ctrl_s pll_ctrl, good;
  logic [VCTL_W-1:0] loop_vctl;
  int fail_count, comparisons, cyc;
  spllc_ctrl_s ctl_tab [3] = '{{1'b1, FB_MIN}, {1'b0, FB_MAX}, {1'b0, FB_RESET}};
  logic [1:0] src_tab [3] = '{SRC_OTP, SRC_EEPROM, SRC_DEFAULT};
  logic [9:0] wr_fb [4] = '{FB_MAX, 10'h22d, 10'h06b, FB_MIN};
  logic [11:0] reg_a [3] = '{ADDR_FREQ_M_LO, ADDR_FREQ_M_HI, ADDR_FREQ_N};
  logic [31:0] reg_v [3] = '{32'h60b9924d, 32'h6, 32'h9e};
  spllc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .otp_img, .eeprom_img, .loop_vctl, .pll_ctrl, .pll_feeds_all_clocks(feeds), .gpio_lol);
  spllc_loop_model loop (.pll_ctrl, .knock, .loop_vctl);
  // ----------------------------------------
  // Clock, tasks and timeout
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  function automatic logic [31:0] cw(input spllc_ctrl_s c);
    return {6'h0, c.fb_div, 15'h0, c.dbl_en};
  endfunction : cw
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic do_reset(input spllc_nvm_s o, input spllc_nvm_s e);
    otp_img <= o;
    eeprom_img <= e;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  // Waits one edge first so two transfers never drive psel twice in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(negedge pclk); while (!pready);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic lock_step(input logic k, input logic [1:0] st);
    apb(1'b1, ADDR_STATUS, 32'h1);
    knock <= k;
    repeat (8) @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("lock status", 32'(rd[1:0]), 32'(st));
    check("gpio_lol", 32'(gpio_lol), 32'(st[0]));
  endtask : lock_step
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, knock, paddr, pwdata, otp_img, eeprom_img} = '0;
    for (int i = 0; i < 3; i++) begin
      do_reset({i != 2, i == 0, 1'b1, FB_MIN}, {1'b1, i != 2, 1'b0, FB_MAX});
      check("pll_ctrl", 32'(pll_ctrl), 32'(ctl_tab[i]));
      check("feeds", 32'(feeds), 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("load status", 32'({rd[5:4], rd[2]}), 32'({src_tab[i], 1'b1}));
    end
    $display("Test load finished");
    good = ctl_tab[2];
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, cw({i == 0, wr_fb[i]}));
      check("ctrl err", 32'(err), 32'(i == 1 || i == 2));
      if (i == 0 || i == 3) good = {i == 0, wr_fb[i]};
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl read", rd, cw(good));
      check("pll_ctrl", 32'(pll_ctrl), 32'(good));
    end
    apb(1'b1, ADDR_CTRL, cw(ctl_tab[2]));
    $display("Test control finished");
    apb(1'b0, ADDR_FREQ_N, 32'h0);
    check("n reset", rd, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, reg_a[i], reg_v[i]);
      apb(1'b0, reg_a[i], 32'h0);
      check("ratio", rd, reg_v[i]);
    end
    $display("Test ratio finished");
    apb(1'b1, ADDR_GPIO_CFG, 32'h1);
    apb(1'b0, ADDR_LOCK_LIM, 32'h0);
    check("lock limits", rd, 32'h02c8_0248);
    lock_step(1'b0, 2'b10);
    lock_step(1'b1, 2'b01);
    lock_step(1'b0, 2'b10);
    $display("Test lock finished");
    apb(1'b1, ADDR_LOCK_LIM, 32'h0);
    check("ro err", 32'(err), 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    $display("Test access finished");
    print_verdict();
  end
endmodule : spllc_tb_top
`default_nettype wire
